// ---- common/wkt_defines.vh ----
`ifndef WKT_DEFINES_VH
`define WKT_DEFINES_VH

// register indices; byte address is four times the index
`define WKT_IDX_CONTROL 8'h23
`define WKT_IDX_RELOAD_HI 8'h24
`define WKT_IDX_RELOAD_LO 8'h25
`define WKT_IDX_COUNT_HI 8'h26
`define WKT_IDX_COUNT_LO 8'h27
`define WKT_IDX_IRQ_STATUS 8'h30
`define WKT_IDX_IRQ_MASK 8'h31

// control register fields
`define WKT_CTL_RUNNING 7
`define WKT_CTL_RUN_CHANGE 6
`define WKT_CTL_AUTO_TRIM 5
`define WKT_CTL_AUTO_CARD 4
`define WKT_CTL_AUTO_RELOAD 3
`define WKT_CTL_AUTO_WAKE 2
`define WKT_CTL_CLK_HI 1
`define WKT_CTL_CLK_LO 0

// interrupt status / mask fields
`define WKT_IRQ_UNDERFLOW 0
`define WKT_IRQ_CARD_FOUND 1
`define WKT_IRQ_NO_CARD 2

// clock select codes and prescaler terminal counts
`define WKT_CLK_DIV1 2'b00
`define WKT_CLK_DIV8 2'b01
`define WKT_CLK_DIV16 2'b10
`define WKT_CLK_DIV32 2'b11
`define WKT_DIV8_LAST 5'h07
`define WKT_DIV16_LAST 5'h0F
`define WKT_DIV32_LAST 5'h1F

// reset values
`define WKT_CTL_RESET 6'h00
`define WKT_RELOAD_RESET 8'h00
`define WKT_COUNT_RESET 16'h0000
`define WKT_IRQ_RESET 3'h0
`define WKT_DATA_RESET 32'h0000_0000
`define WKT_FLAG_RESET 1'b0
`define WKT_PRESCALE_RESET 5'h00

`endif

// ---- rtl/wkt_timer.v ----
// Local design decision: register access over APB.
`timescale 1ns/1ns
`include "wkt_defines.vh"

// Contract
// - control bit 7 reads back whether the wake-up timer is counting.
// - the running bit sets only on a control write that sets bit 6; it clears on such a write or when a non-reloading count underflows.
// - with auto_osc_trim set, every underflow pulses the oscillator trim start.
// - with auto_card_detect set, underflow starts card sensing; a found card raises an interrupt.
// - when sensing finds no card and power-down entry is enabled, power-down is requested.
// - during auto card detection the countdown reloads at underflow with no gap.
// - auto_reload set reloads at zero and keeps counting; with auto_reload and auto_card_detect both clear it counts to zero and stops.
// - every underflow sets the wake-up timer interrupt flag.
// - with auto_wake set, every underflow pulses a wake request.
// - clock select 00 counts the oscillator undivided, 01 by 8, 10 by 16, 11 by 32.
// - each start event loads the counter from reload high and low bytes.
// - writing the reload bytes does not disturb a running count.
// - the live counter is readable as high and low bytes.
module wkt_timer #(
    parameter ADDR_WIDTH = 12
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_WIDTH-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire lfo_clk_in,
    input wire card_detect_done,
    input wire card_present,
    output reg trim_start,
    output reg card_detect_start,
    output reg wake_request,
    output reg power_down_request,
    output reg underflow_flag,
    output reg irq
);

    // registers
    reg running_q;
    reg running_d;
    reg auto_trim_q;
    reg auto_card_q;
    reg auto_reload_q;
    reg auto_wake_q;
    reg [1:0] clk_sel_q;
    reg [7:0] reload_hi_q;
    reg [7:0] reload_lo_q;
    reg [15:0] count_q;
    reg [15:0] count_d;
    reg [2:0] irq_status_q;
    reg [2:0] irq_status_d;
    reg [2:0] irq_mask_q;
    reg [4:0] prescale_q;
    reg [4:0] prescale_d;
    reg lfo_sync1_q;
    reg lfo_sync2_q;
    reg lfo_prev_q;
    reg card_busy_q;
    reg card_busy_d;

    wire [15:0] reload_value;
    wire apb_setup_done;
    wire wr_commit;
    wire [7:0] wr_byte;
    wire [7:0] index;
    wire lfo_edge;
    wire wr_ok;
    wire card_result;
    reg tick;
    reg underflow;
    reg start_event;
    reg stop_event;
    reg [7:0] rd_byte;
    reg mapped;

    function [4:0] div_last;
        input [1:0] sel;
        begin
            case (sel)
                `WKT_CLK_DIV8: div_last = `WKT_DIV8_LAST;
                `WKT_CLK_DIV16: div_last = `WKT_DIV16_LAST;
                `WKT_CLK_DIV32: div_last = `WKT_DIV32_LAST;
                default: div_last = 5'h00;
            endcase
        end
    endfunction

    function is_reg;
        input [7:0] idx;
        input [7:0] want;
        begin
            is_reg = (idx == want);
        end
    endfunction

    assign reload_value = {reload_hi_q, reload_lo_q};
    assign index = paddr[9:2];
    assign apb_setup_done = psel & penable & ~pready;
    // one wait state: pready rises one edge into the access phase, writes land on the next edge, while pready is high
    assign wr_commit = psel & penable & pready & pwrite;
    // a refused access must leave every register and the timer as they were
    assign wr_ok = wr_commit & mapped;
    assign wr_byte = pwdata[7:0];
    assign lfo_edge = lfo_sync2_q & ~lfo_prev_q;
    // a done pulse with no sensing run pending is ignored
    assign card_result = card_busy_q & card_detect_done;

    // the oscillator pin is asynchronous to pclk, so it passes two flops first
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfo_sync1_q <= `WKT_FLAG_RESET;
            lfo_sync2_q <= `WKT_FLAG_RESET;
            lfo_prev_q <= `WKT_FLAG_RESET;
        end else begin
            lfo_sync1_q <= lfo_clk_in;
            lfo_sync2_q <= lfo_sync1_q;
            lfo_prev_q <= lfo_sync2_q;
        end
    end

    // prescaler: tick on every oscillator edge, or every 8th, 16th, 32nd
    always @* begin
        prescale_d = prescale_q;
        tick = 1'b0;
        if (!running_q) begin
            prescale_d = 5'h00;
        end else if (lfo_edge) begin
            // >= so a smaller divider chosen mid-count wraps at once, not after 32 edges
            if (prescale_q >= div_last(clk_sel_q)) begin
                prescale_d = 5'h00;
                tick = 1'b1;
            end else begin
                prescale_d = prescale_q + 5'h01;
            end
        end
    end

    always @* begin
        start_event = 1'b0;
        stop_event = 1'b0;
        if (wr_ok && is_reg(index, `WKT_IDX_CONTROL) && wr_byte[`WKT_CTL_RUN_CHANGE]) begin
            start_event = wr_byte[`WKT_CTL_RUNNING];
            stop_event = ~wr_byte[`WKT_CTL_RUNNING];
        end
    end

    // countdown; reload bytes are only sampled at a start or an automatic reload
    always @* begin
        count_d = count_q;
        running_d = running_q;
        underflow = 1'b0;
        if (start_event) begin
            running_d = 1'b1;
            count_d = reload_value;
        end else if (stop_event) begin
            running_d = 1'b0;
        end else if (running_q && tick) begin
            if (count_q == 16'h0000) begin
                underflow = 1'b1;
                if (auto_reload_q || auto_card_q) begin
                    count_d = reload_value;
                end else begin
                    running_d = 1'b0;
                end
            end else begin
                count_d = count_q - 16'h0001;
            end
        end
    end

    // card sensing runs outside; this only tracks that a sequence is pending
    always @* begin
        card_busy_d = card_busy_q;
        if (card_detect_done) begin
            card_busy_d = 1'b0;
        end
        if (underflow && auto_card_q) begin
            card_busy_d = 1'b1;
        end
    end

    // sticky status, write one to clear; a new event in the same cycle wins
    always @* begin
        irq_status_d = irq_status_q;
        if (wr_ok && is_reg(index, `WKT_IDX_IRQ_STATUS)) begin
            irq_status_d = irq_status_q & ~wr_byte[2:0];
        end
        if (underflow) begin
            irq_status_d[`WKT_IRQ_UNDERFLOW] = 1'b1;
        end
        if (card_result && card_present) begin
            irq_status_d[`WKT_IRQ_CARD_FOUND] = 1'b1;
        end
        if (card_result && !card_present) begin
            irq_status_d[`WKT_IRQ_NO_CARD] = 1'b1;
        end
    end

    always @* begin
        mapped = 1'b1;
        rd_byte = 8'h00;
        case (index)
            `WKT_IDX_CONTROL: rd_byte = {running_q, 1'b0, auto_trim_q, auto_card_q,
                auto_reload_q, auto_wake_q, clk_sel_q};
            `WKT_IDX_RELOAD_HI: rd_byte = reload_hi_q;
            `WKT_IDX_RELOAD_LO: rd_byte = reload_lo_q;
            // bytes are read live and may tear while counting; read twice for a stable value
            `WKT_IDX_COUNT_HI: rd_byte = count_q[15:8];
            `WKT_IDX_COUNT_LO: rd_byte = count_q[7:0];
            `WKT_IDX_IRQ_STATUS: rd_byte = {5'h00, irq_status_q};
            `WKT_IDX_IRQ_MASK: rd_byte = {5'h00, irq_mask_q};
            default: mapped = 1'b0;
        endcase
        if (paddr[1:0] != 2'b00 || |paddr[ADDR_WIDTH-1:10]) begin
            mapped = 1'b0;
        end
    end

    // apb answer and software-written fields
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= `WKT_FLAG_RESET;
            pslverr <= `WKT_FLAG_RESET;
            prdata <= `WKT_DATA_RESET;
            {auto_trim_q, auto_card_q, auto_reload_q, auto_wake_q, clk_sel_q} <= `WKT_CTL_RESET;
            reload_hi_q <= `WKT_RELOAD_RESET;
            reload_lo_q <= `WKT_RELOAD_RESET;
            irq_mask_q <= `WKT_IRQ_RESET;
        end else begin
            pready <= apb_setup_done;
            pslverr <= apb_setup_done & ~mapped;
            if (apb_setup_done && !pwrite && mapped) begin
                prdata <= {24'h00_0000, rd_byte};
            end else begin
                prdata <= `WKT_DATA_RESET;
            end
            if (wr_ok) begin
                case (index)
                    `WKT_IDX_CONTROL: begin
                        auto_trim_q <= wr_byte[`WKT_CTL_AUTO_TRIM];
                        auto_card_q <= wr_byte[`WKT_CTL_AUTO_CARD];
                        auto_reload_q <= wr_byte[`WKT_CTL_AUTO_RELOAD];
                        auto_wake_q <= wr_byte[`WKT_CTL_AUTO_WAKE];
                        clk_sel_q <= wr_byte[`WKT_CTL_CLK_HI:`WKT_CTL_CLK_LO];
                    end
                    `WKT_IDX_RELOAD_HI: reload_hi_q <= wr_byte;
                    `WKT_IDX_RELOAD_LO: reload_lo_q <= wr_byte;
                    `WKT_IDX_IRQ_MASK: irq_mask_q <= wr_byte[2:0];
                    default: irq_mask_q <= irq_mask_q;
                endcase
            end
        end
    end

    // timer core
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            running_q <= `WKT_FLAG_RESET;
            count_q <= `WKT_COUNT_RESET;
            prescale_q <= `WKT_PRESCALE_RESET;
            card_busy_q <= `WKT_FLAG_RESET;
            irq_status_q <= `WKT_IRQ_RESET;
        end else begin
            running_q <= running_d;
            count_q <= count_d;
            prescale_q <= prescale_d;
            card_busy_q <= card_busy_d;
            irq_status_q <= irq_status_d;
        end
    end

    // event outputs come from flops so the outside controllers never see a decode glitch
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_start <= `WKT_FLAG_RESET;
            card_detect_start <= `WKT_FLAG_RESET;
            wake_request <= `WKT_FLAG_RESET;
            power_down_request <= `WKT_FLAG_RESET;
            underflow_flag <= `WKT_FLAG_RESET;
            irq <= `WKT_FLAG_RESET;
        end else begin
            trim_start <= underflow & auto_trim_q;
            card_detect_start <= underflow & auto_card_q;
            wake_request <= underflow & auto_wake_q;
            // auto_wake doubles as the power-down entry enable after a sensing run
            power_down_request <= card_result & ~card_present & auto_wake_q;
            underflow_flag <= irq_status_d[`WKT_IRQ_UNDERFLOW];
            // irq follows the next status so a new event shows without an extra cycle
            irq <= |(irq_status_d & irq_mask_q);
        end
    end

endmodule

// ---- dv/wkt_timer_props.sv ----
`timescale 1ns/1ns
module wkt_timer_props #(
    parameter ADDR_WIDTH = 12
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_WIDTH-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire lfo_clk_in,
    input wire card_detect_done,
    input wire card_present,
    input wire trim_start,
    input wire card_detect_start,
    input wire wake_request,
    input wire power_down_request,
    input wire underflow_flag,
    input wire irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready; psel && penable && !pready |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("access not answered");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held");
    property p_idle; !pready |-> prdata == 32'h0000_0000; endproperty
    a_idle: assert property (p_idle) else $error("read data outside answer");
    property p_upper; pready |-> prdata[31:8] == 24'h00_0000; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_trim; trim_start |-> underflow_flag ##1 !trim_start; endproperty
    a_trim: assert property (p_trim) else $error("trim start without underflow");
    property p_card; card_detect_start |-> underflow_flag; endproperty
    a_card: assert property (p_card) else $error("card start without underflow");
    property p_wake; wake_request |-> underflow_flag ##1 !wake_request; endproperty
    a_wake: assert property (p_wake) else $error("wake without underflow");
    property p_pdown; power_down_request |-> $past(card_detect_done && !card_present); endproperty
    a_pdown: assert property (p_pdown) else $error("power down without empty result");
    c_trim: cover property (trim_start);
    c_card: cover property (card_detect_start);
    c_pdown: cover property (power_down_request);
endmodule

bind wkt_timer wkt_timer_props #(.ADDR_WIDTH(ADDR_WIDTH)) props_u (.*);

// ---- dv/wkt_timer_bench.sv ----
`timescale 1ns/1ns
`include "wkt_defines.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module wkt_timer_bench;
reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
reg lfo_clk_in = 0, card_detect_done = 0, card_present = 0, err;
reg [11:0] paddr = 0;
reg [31:0] pwdata = 0, rd, r;
wire [31:0] prdata;
wire pready, pslverr, trim_start, card_detect_start, wake_request, power_down_request;
wire underflow_flag, irq;
integer error_cnt = 0, tests_run = 0, seed = 32'h1dd4, cyc = 0;
integer cnt = 0, rel = 0, run = 0, flg = 0, ar, aw, at, i, k, ew = 0, et = 0;
integer nw = 0, nt = 0, np = 0, nc = 0, ec = 0, ac = 0;
always #10 pclk = ~pclk;
wkt_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lfo_clk_in(lfo_clk_in), .card_detect_done(card_detect_done),
    .card_present(card_present), .trim_start(trim_start),
    .card_detect_start(card_detect_start), .wake_request(wake_request),
    .power_down_request(power_down_request), .underflow_flag(underflow_flag), .irq(irq));
task print_verdict;
    begin
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
endtask
always @(posedge pclk) begin
    cyc = cyc + 1;
    nw = nw + (wake_request === 1'b1);
    nt = nt + (trim_start === 1'b1);
    np = np + (power_down_request === 1'b1);
    nc = nc + (card_detect_start === 1'b1);
    if (cyc == 40000) begin
        error_cnt++;
        print_verdict;
    end
end
task apb(input w, input [7:0] idx, input [7:0] d);
    integer n;
    begin
        n = 0;
        r = $random(seed);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {r[23:0], d};
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16) begin
            @(posedge pclk);
            n = n + 1;
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        if (pready !== 1'b1) begin
            error_cnt++;
            print_verdict;
        end
    end
endtask
task rdchk(input [7:0] idx, input [7:0] e);
    begin
        apb(0, idx, 8'h00);
        `CHK({err, rd}, {25'h000_0000, e})
    end
endtask
task cntchk;
    begin
        rdchk(`WKT_IDX_COUNT_HI, cnt[15:8]);
        rdchk(`WKT_IDX_COUNT_LO, cnt[7:0]);
    end
endtask
task start(input [7:0] c);
    begin
        apb(1, `WKT_IDX_CONTROL, c | 8'hC0);
        run = 1;
        cnt = rel;
        ar = c[3] | c[4];
        aw = c[2];
        at = c[5];
        ac = c[4];
    end
endtask
// the pin is slow; each rising edge needs three pclk edges to reach the counter
task edges(input integer m);
    repeat (m) begin
        @(posedge pclk);
        lfo_clk_in <= 1;
        repeat (3) @(posedge pclk);
        lfo_clk_in <= 0;
        repeat (3) @(posedge pclk);
    end
endtask
task tick(input integer m);
    begin
        edges(m);
        if (run && cnt == 0) begin
            flg = 1;
            ew = ew + aw;
            et = et + at;
            ec = ec + ac;
            cnt = ar ? rel : 0;
            run = ar;
        end else if (run)
            cnt = cnt - 1;
    end
endtask
task card(input p);
    begin
        @(posedge pclk);
        card_detect_done <= 1;
        card_present <= p;
        @(posedge pclk);
        card_detect_done <= 0;
    end
endtask
initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    rdchk(`WKT_IDX_CONTROL, 8'h00);
    cntchk;
    apb(0, 8'h40, 8'h00);
    `CHK({err, rd}, 33'h1_0000_0000)
    apb(1, `WKT_IDX_CONTROL, 8'h80);
    rdchk(`WKT_IDX_CONTROL, 8'h00);
    apb(1, `WKT_IDX_IRQ_MASK, 8'h07);
    r = $random(seed);
    rel = r[2:0] + 1;
    k = rel;
    apb(1, `WKT_IDX_RELOAD_LO, rel[7:0]);
    start(8'h0C);
    rdchk(`WKT_IDX_CONTROL, 8'h8C);
    cntchk;
    r = $random(seed);
    rel = {r[7:0], 8'hF0};
    apb(1, `WKT_IDX_RELOAD_HI, rel[15:8]);
    apb(1, `WKT_IDX_RELOAD_LO, 8'hF0);
    for (i = 0; i < k + 3; i++) begin
        tick(1);
        cntchk;
        `CHK({underflow_flag, irq}, {flg[0], flg[0]})
    end
    apb(1, `WKT_IDX_IRQ_MASK, 8'h00);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1, `WKT_IDX_IRQ_STATUS, 8'h01);
    rdchk(`WKT_IDX_IRQ_STATUS, 8'h00);
    apb(1, `WKT_IDX_CONTROL, 8'h40);
    run = 0;
    tick(1);
    cntchk;
    rel = 1;
    apb(1, `WKT_IDX_RELOAD_HI, 8'h00);
    apb(1, `WKT_IDX_RELOAD_LO, 8'h01);
    for (k = 1; k < 4; k++) begin
        start(k);
        edges((4 << k) - 1);
        cntchk;
        tick(1);
        cntchk;
        tick(4 << k);
        rdchk(`WKT_IDX_CONTROL, k);
    end
    rel = 2;
    apb(1, `WKT_IDX_RELOAD_LO, 8'h02);
    apb(1, `WKT_IDX_IRQ_STATUS, 8'h07);
    start(8'h34);
    for (k = 0; k < 2; k++) begin
        repeat (3) tick(1);
        cntchk;
        card(k);
        rdchk(`WKT_IDX_IRQ_STATUS, k ? 8'h07 : 8'h05);
    end
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    cnt = 0;
    rdchk(`WKT_IDX_CONTROL, 8'h00);
    cntchk;
    `CHK({underflow_flag, irq}, 2'b00)
    `CHK(nc, ec)
    `CHK(np, 1)
    `CHK(nw, ew)
    `CHK(nt, et)
    print_verdict;
end
endmodule
